// >>> logic/xma_pkg.sv
// Purpose: Shared constants and types for the extended memory ALU datapath
// Assumes: 8-bit data, one system clock
// Notes: Operation codes are local to this block, not instruction encodings
package xma_pkg;

	// ----------------------------------------
	// Widths and constants
	// ----------------------------------------
	localparam int XMA_DATA_W = 8;
	localparam int XMA_ADDR_W = 12;
	localparam logic [7:0] XMA_ALL_ONES = 8'hff;
	localparam logic [7:0] XMA_ZERO = 8'h00;
	localparam logic [7:0] XMA_ONE = 8'h01;
	localparam logic [7:0] XMA_ACC_RST = 8'h00;
	// Flag vector bit positions
	localparam int XMA_FLG_C = 0;
	localparam int XMA_FLG_AC = 1;
	localparam int XMA_FLG_Z = 2;
	localparam int XMA_FLG_OV = 3;
	localparam int XMA_FLG_SC = 4;
	localparam int XMA_FLG_CZ = 5;
	localparam int XMA_FLG_W = 6;
	localparam logic [5:0] XMA_FLG_RST = 6'h00;

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [4:0] {
		XMA_OP_NONE = 5'h00,
		XMA_OP_OR_ACC = 5'h01,
		XMA_OP_OR_MEM = 5'h02,
		XMA_OP_RL_MEM = 5'h03,
		XMA_OP_RL_ACC = 5'h04,
		XMA_OP_RLC_MEM = 5'h05,
		XMA_OP_RLC_ACC = 5'h06,
		XMA_OP_RR_MEM = 5'h07,
		XMA_OP_RR_ACC = 5'h08,
		XMA_OP_RRC_MEM = 5'h09,
		XMA_OP_RRC_ACC = 5'h0a,
		XMA_OP_SBC_ACC = 5'h0b,
		XMA_OP_SBC_MEM = 5'h0c,
		XMA_OP_SUB_ACC = 5'h0d,
		XMA_OP_SUB_MEM = 5'h0e,
		XMA_OP_DSZ_MEM = 5'h0f,
		XMA_OP_DSZ_ACC = 5'h10,
		XMA_OP_ISZ_MEM = 5'h11,
		XMA_OP_ISZ_ACC = 5'h12,
		XMA_OP_SET_BYTE = 5'h13,
		XMA_OP_SET_BIT = 5'h14,
		XMA_OP_SNZ_BIT = 5'h15,
		XMA_OP_SNZ_BYTE = 5'h16,
		XMA_OP_SWAP_MEM = 5'h17
	} xma_op_type;

	// Two-state sequencer: execute, or dummy cycle after a skip
	typedef enum logic {
		XMA_ST_EXEC = 1'b0,
		XMA_ST_DUMMY = 1'b1
	} xma_state_type;

endpackage

// >>> logic/xma_subtractor.sv
// Purpose: 8-bit subtract with borrow, giving carry, aux carry and overflow flags
// Assumes: Carry in is an inverted borrow (1 means no borrow)
// Notes: Purely combinational
module xma_subtractor #(
	parameter int WIDTH = 8
) (
	// Operands
	input wire logic [WIDTH-1:0] minuend,
	input wire logic [WIDTH-1:0] subtrahend,
	input wire logic carry_in,
	// Results
	output logic [WIDTH-1:0] diff,
	output logic carry_out,
	output logic aux_carry_out,
	output logic overflow_out
);

	// ----------------------------------------
	// Add the one's complement plus carry
	// ----------------------------------------
	wire logic [WIDTH:0] full_sum;
	wire logic [4:0] low_sum;

	// Carry out high means no borrow
	assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, carry_in};
	assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
	assign diff = full_sum[WIDTH-1:0];
	assign carry_out = full_sum[WIDTH];
	assign aux_carry_out = low_sum[4];
	// Signed overflow when operand signs differ and result sign flips
	assign overflow_out = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1])
		& (minuend[WIDTH-1] ^ full_sum[WIDTH-1]);

endmodule

// >>> logic/xma_alu.sv
// Purpose: Datapath for the long-address OR, rotate, subtract, skip, set and swap group
// Assumes: Decoder supplies one op pulse with the memory byte already read
// Notes: Memory is flat-addressed; results register one cycle after op_valid
//
// Overview of operation
// - OR accumulator with memory byte; result to acc or memory; zero flag only.
// - Rotate left wraps bit 7 into bit 0; no flags change.
// - Accumulator-destination rotates write the accumulator and leave memory alone.
// - Rotate left through carry: carry into bit 0, bit 7 into carry.
// - Rotate right wraps bit 0 into bit 7; no flags change.
// - Rotate right through carry: carry into bit 7, bit 0 into carry.
// - Subtract with carry: acc minus memory minus inverted carry.
// - Subtraction clears carry when negative, sets it otherwise.
// - Subtractions update overflow, zero, aux carry, carry, signed and combined zero.
// - Plain subtract: acc minus memory, to acc or memory.
// - Decrement memory, write back, skip if result zero; no flags.
// - Memory minus one into acc, memory kept, skip if zero.
// - Increment memory, write back, skip if wrapped to zero; no flags.
// - Memory plus one into acc, memory kept, skip if zero.
// - A taken skip inserts one dummy cycle, two cycles in total.
// - Set byte writes all ones to memory; flags unchanged.
// - Set bit forces the chosen bit to one, others kept.
// - Bit skip-if-nonzero skips when the chosen bit is one.
// - Byte skip-if-nonzero skips when the whole byte is nonzero.
// - Nibble swap exchanges high and low nibbles in memory.
// - Any memory address is reachable directly, with no bank switching.
module xma_alu #(
	parameter int ADDR_W = xma_pkg::XMA_ADDR_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Operation request from the decoder
	input wire logic op_valid,
	input wire xma_pkg::xma_op_type op_code,
	input wire logic [ADDR_W-1:0] op_addr,
	input wire logic [2:0] op_bit,
	input wire logic [7:0] mem_rdata,
	// Memory write port
	output logic mem_we,
	output logic [ADDR_W-1:0] mem_waddr,
	output logic [7:0] mem_wdata,
	// Architectural state
	output logic [7:0] accumulator_reg,
	output logic [5:0] flags,
	// Sequencing
	output logic skip_taken,
	output logic dummy_cycle,
	output logic busy
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	xma_pkg::xma_state_type state_q, state_d;
	logic [7:0] acc_q, acc_d;
	logic [5:0] flg_q, flg_d;
	logic mem_we_q;
	logic [ADDR_W-1:0] mem_waddr_q;
	logic [7:0] mem_wdata_q;
	logic skip_q, dummy_q;

	wire logic accept;
	wire logic carry_q;
	wire logic [7:0] or_res;
	wire logic [7:0] rl_res;
	wire logic [7:0] rlc_res;
	wire logic [7:0] rr_res;
	wire logic [7:0] rrc_res;
	wire logic [7:0] dec_res;
	wire logic [7:0] inc_res;
	wire logic [7:0] swap_res;
	wire logic [7:0] setbit_res;
	wire logic [7:0] bit_mask;
	wire logic [7:0] sub_res;
	wire logic sub_c, sub_ac, sub_ov;
	wire logic sub_cin;
	wire logic is_sbc, is_sub, is_rot_c, is_or;
	wire logic to_acc, to_mem, skip_now;
	wire logic [7:0] result;
	wire logic res_zero;

	// ----------------------------------------
	// Operand decoding
	// ----------------------------------------
	// New ops are refused during the dummy cycle of a skip
	assign accept = op_valid && (state_q == xma_pkg::XMA_ST_EXEC);
	assign carry_q = flg_q[xma_pkg::XMA_FLG_C];
	assign bit_mask = xma_pkg::XMA_ONE << op_bit;

	assign or_res = acc_q | mem_rdata;
	assign rl_res = {mem_rdata[6:0], mem_rdata[7]};
	assign rlc_res = {mem_rdata[6:0], carry_q};
	assign rr_res = {mem_rdata[0], mem_rdata[7:1]};
	assign rrc_res = {carry_q, mem_rdata[7:1]};
	assign dec_res = mem_rdata - xma_pkg::XMA_ONE;
	assign inc_res = mem_rdata + xma_pkg::XMA_ONE;
	assign swap_res = {mem_rdata[3:0], mem_rdata[7:4]};
	assign setbit_res = mem_rdata | bit_mask;

	// ----------------------------------------
	// Subtraction
	// ----------------------------------------
	assign is_sbc = (op_code == xma_pkg::XMA_OP_SBC_ACC) || (op_code == xma_pkg::XMA_OP_SBC_MEM);
	assign is_sub = is_sbc || (op_code == xma_pkg::XMA_OP_SUB_ACC)
		|| (op_code == xma_pkg::XMA_OP_SUB_MEM);
	// plain subtract behaves as no borrow in
	assign sub_cin = is_sbc ? carry_q : 1'b1;

	xma_subtractor #(
		.WIDTH(xma_pkg::XMA_DATA_W)
	) u_sub (
		.minuend(acc_q),
		.subtrahend(mem_rdata),
		.carry_in(sub_cin),
		.diff(sub_res),
		.carry_out(sub_c),
		.aux_carry_out(sub_ac),
		.overflow_out(sub_ov)
	);

	// ----------------------------------------
	// Result select and destinations
	// ----------------------------------------
	assign is_or = (op_code == xma_pkg::XMA_OP_OR_ACC) || (op_code == xma_pkg::XMA_OP_OR_MEM);
	assign is_rot_c = (op_code == xma_pkg::XMA_OP_RLC_MEM) || (op_code == xma_pkg::XMA_OP_RLC_ACC)
		|| (op_code == xma_pkg::XMA_OP_RRC_MEM) || (op_code == xma_pkg::XMA_OP_RRC_ACC);

	// set byte selects all ones, flags untouched
	assign result =
		is_or ? or_res :
		((op_code == xma_pkg::XMA_OP_RL_MEM) || (op_code == xma_pkg::XMA_OP_RL_ACC)) ? rl_res :
		((op_code == xma_pkg::XMA_OP_RLC_MEM) || (op_code == xma_pkg::XMA_OP_RLC_ACC)) ? rlc_res :
		((op_code == xma_pkg::XMA_OP_RR_MEM) || (op_code == xma_pkg::XMA_OP_RR_ACC)) ? rr_res :
		((op_code == xma_pkg::XMA_OP_RRC_MEM) || (op_code == xma_pkg::XMA_OP_RRC_ACC)) ? rrc_res :
		is_sub ? sub_res :
		((op_code == xma_pkg::XMA_OP_DSZ_MEM) || (op_code == xma_pkg::XMA_OP_DSZ_ACC)) ? dec_res :
		((op_code == xma_pkg::XMA_OP_ISZ_MEM) || (op_code == xma_pkg::XMA_OP_ISZ_ACC)) ? inc_res :
		(op_code == xma_pkg::XMA_OP_SET_BYTE) ? xma_pkg::XMA_ALL_ONES :
		(op_code == xma_pkg::XMA_OP_SET_BIT) ? setbit_res :
		(op_code == xma_pkg::XMA_OP_SWAP_MEM) ? swap_res : mem_rdata;

	// zero test on the 8-bit result
	assign res_zero = (result == xma_pkg::XMA_ZERO);

	assign to_acc = (op_code == xma_pkg::XMA_OP_OR_ACC) || (op_code == xma_pkg::XMA_OP_RL_ACC)
		|| (op_code == xma_pkg::XMA_OP_RLC_ACC) || (op_code == xma_pkg::XMA_OP_RR_ACC)
		|| (op_code == xma_pkg::XMA_OP_RRC_ACC) || (op_code == xma_pkg::XMA_OP_SBC_ACC)
		|| (op_code == xma_pkg::XMA_OP_SUB_ACC) || (op_code == xma_pkg::XMA_OP_DSZ_ACC)
		|| (op_code == xma_pkg::XMA_OP_ISZ_ACC);
	assign to_mem = !to_acc && (op_code != xma_pkg::XMA_OP_NONE)
		&& (op_code != xma_pkg::XMA_OP_SNZ_BIT) && (op_code != xma_pkg::XMA_OP_SNZ_BYTE);

	// Skip conditions
	assign skip_now =
		(((op_code == xma_pkg::XMA_OP_DSZ_MEM) || (op_code == xma_pkg::XMA_OP_DSZ_ACC)
		|| (op_code == xma_pkg::XMA_OP_ISZ_MEM) || (op_code == xma_pkg::XMA_OP_ISZ_ACC))
		&& res_zero)
		|| ((op_code == xma_pkg::XMA_OP_SNZ_BIT) && ((mem_rdata & bit_mask) != xma_pkg::XMA_ZERO))
		|| ((op_code == xma_pkg::XMA_OP_SNZ_BYTE) && (mem_rdata != xma_pkg::XMA_ZERO));

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		acc_d = acc_q;
		flg_d = flg_q;
		state_d = xma_pkg::XMA_ST_EXEC;
		if (accept) begin
			if (to_acc) begin
				acc_d = result;
			end
			if (is_or) begin
				flg_d[xma_pkg::XMA_FLG_Z] = res_zero;
			end
			if (is_rot_c) begin
				flg_d[xma_pkg::XMA_FLG_C] = ((op_code == xma_pkg::XMA_OP_RLC_MEM)
					|| (op_code == xma_pkg::XMA_OP_RLC_ACC)) ? mem_rdata[7] : mem_rdata[0];
			end
			if (is_sub) begin
				flg_d[xma_pkg::XMA_FLG_C] = sub_c;
				flg_d[xma_pkg::XMA_FLG_AC] = sub_ac;
				flg_d[xma_pkg::XMA_FLG_OV] = sub_ov;
				flg_d[xma_pkg::XMA_FLG_Z] = res_zero;
				flg_d[xma_pkg::XMA_FLG_SC] = sub_res[7] ^ sub_ov;
				// Combined zero chains with prior zero only for the borrow form
				flg_d[xma_pkg::XMA_FLG_CZ] = is_sbc ? (res_zero & flg_q[xma_pkg::XMA_FLG_CZ])
					: res_zero;
			end
			// taken skip adds a dummy cycle
			if (skip_now) begin
				state_d = xma_pkg::XMA_ST_DUMMY;
			end
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= xma_pkg::XMA_ST_EXEC;
			acc_q <= xma_pkg::XMA_ACC_RST;
			flg_q <= xma_pkg::XMA_FLG_RST;
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			flg_q <= flg_d;
		end
	end

	// Memory write port, address taken whole so no banking applies
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mem_we_q <= 1'b0;
			mem_waddr_q <= '0;
			mem_wdata_q <= xma_pkg::XMA_ZERO;
		end else begin
			mem_we_q <= accept && to_mem;
			mem_waddr_q <= op_addr;
			mem_wdata_q <= result;
		end
	end

	// Skip pulse and dummy-cycle marker
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			skip_q <= 1'b0;
			dummy_q <= 1'b0;
		end else begin
			skip_q <= accept && skip_now;
			dummy_q <= (state_d == xma_pkg::XMA_ST_DUMMY);
		end
	end

	assign mem_we = mem_we_q;
	assign mem_waddr = mem_waddr_q;
	assign mem_wdata = mem_wdata_q;
	assign accumulator_reg = acc_q;
	assign flags = flg_q;
	assign skip_taken = skip_q;
	assign dummy_cycle = dummy_q;
	assign busy = dummy_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// one dummy cycle only
	a_skip_dummy_len: assert property (@(posedge clock) disable iff (!rst_n)
		skip_taken |-> dummy_cycle ##1 !dummy_cycle)
		else $error("skip did not give exactly one dummy cycle");
	a_acc_no_memw: assert property (@(posedge clock) disable iff (!rst_n)
		accept && to_acc |=> !mem_we)
		else $error("accumulator op wrote memory");
	a_rl_wrap: assert property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_RL_MEM |=>
		mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}
		&& flags == $past(flags))
		else $error("rotate left result wrong");
	a_rrc_carry: assert property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_RRC_ACC |=>
		accumulator_reg[7] == $past(flags[0]) && flags[0] == $past(mem_rdata[0]))
		else $error("rotate right through carry wrong");
	a_sub_carry: assert property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_SUB_ACC |=>
		flags[0] == ($past(accumulator_reg) >= $past(mem_rdata)))
		else $error("subtract carry not inverted borrow");
	a_or_zero: assert property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_OR_ACC |=>
		accumulator_reg == ($past(accumulator_reg) | $past(mem_rdata))
		&& flags[2] == (accumulator_reg == 8'h00) && flags[1:0] == $past(flags[1:0]))
		else $error("or result or zero flag wrong");
	a_dsz_skip: assert property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_DSZ_MEM && mem_rdata == 8'h01 |=>
		skip_taken && mem_we && mem_wdata == 8'h00)
		else $error("decrement skip missed");
	a_snz_byte: assert property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_SNZ_BYTE |=>
		skip_taken == ($past(mem_rdata) != 8'h00) && !mem_we)
		else $error("byte nonzero skip wrong");
	a_set_byte: assert property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_SET_BYTE |=> mem_wdata == 8'hff && mem_we)
		else $error("set byte not all ones");

	c_skip: cover property (@(posedge clock) disable iff (!rst_n) skip_taken);
	c_sbc_borrow: cover property (@(posedge clock) disable iff (!rst_n)
		accept && is_sbc && !sub_c);
	c_swap: cover property (@(posedge clock) disable iff (!rst_n)
		accept && op_code == xma_pkg::XMA_OP_SWAP_MEM);

endmodule

// >>> test/xma_mem_model.sv
// Purpose: Data memory partner for the extended memory ALU datapath
// Assumes: Read is combinational on op_addr while op_valid is high
// Notes: Outside a request the read bus shows the inverse byte, never a held value
module xma_mem_model (
	// Clock
	input wire logic clock,
	// Read side
	input wire logic op_valid,
	input wire logic [11:0] op_addr,
	output logic [7:0] mem_rdata,
	// Write side
	input wire logic mem_we,
	input wire logic [11:0] mem_waddr,
	input wire logic [7:0] mem_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Plain always so the bench may preset bytes directly
	logic [7:0] mem [0:4095];

	assign mem_rdata = op_valid ? mem[op_addr] : ~mem[op_addr];

	// Write at the edge while the strobe stands
	always @(posedge clock) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end
endmodule

// >>> test/testbench.sv
// Purpose: Self-checking bench for the extended memory ALU datapath
// Assumes: Ops driven at the falling edge, two idle cycles between ops
// Notes: Expected values come from a small reference kept in the bench
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clock, rst_n, op_valid, mem_we, skip_taken, dummy_cycle, busy;
	xma_pkg::xma_op_type op_code;
	logic [11:0] op_addr, mem_waddr;
	logic [2:0] op_bit;
	logic [7:0] mem_rdata, mem_wdata, accumulator_reg;
	logic [5:0] flags;
	int error_cnt = 0;
	int tests_run = 0;
	// Reference acc and flags: [0]C [1]AC [2]Z [3]OV [4]SC [5]CZ
	logic [7:0] ea = 8'h00;
	logic [5:0] ef = 6'h00;

	xma_alu #(.ADDR_W(12)) u_dut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid),
		.op_code(op_code), .op_addr(op_addr), .op_bit(op_bit), .mem_rdata(mem_rdata),
		.mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
		.accumulator_reg(accumulator_reg), .flags(flags), .skip_taken(skip_taken),
		.dummy_cycle(dummy_cycle), .busy(busy));
	xma_mem_model u_mem (.clock(clock), .op_valid(op_valid), .op_addr(op_addr),
		.mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One op against the reference; a refused request is offered in any dummy cycle
	task automatic exec(input xma_pkg::xma_op_type op, input logic [11:0] a, input logic [2:0] b);
		logic [7:0] m, r, d0;
		logic [8:0] d;
		logic [4:0] lo;
		logic to_mem, sk, cin, sbc;
		m = u_mem.mem[a];
		d0 = u_mem.mem[12'h000];
		r = ea;
		sk = 1'b0;
		to_mem = op inside {xma_pkg::XMA_OP_OR_MEM, xma_pkg::XMA_OP_RL_MEM,
			xma_pkg::XMA_OP_RLC_MEM, xma_pkg::XMA_OP_RR_MEM, xma_pkg::XMA_OP_RRC_MEM,
			xma_pkg::XMA_OP_SBC_MEM, xma_pkg::XMA_OP_SUB_MEM, xma_pkg::XMA_OP_DSZ_MEM,
			xma_pkg::XMA_OP_ISZ_MEM, xma_pkg::XMA_OP_SET_BYTE, xma_pkg::XMA_OP_SET_BIT,
			xma_pkg::XMA_OP_SWAP_MEM};
		case (op)
			xma_pkg::XMA_OP_OR_ACC, xma_pkg::XMA_OP_OR_MEM: begin
				r = ea | m;
				ef[2] = (r == 8'h00);
			end
			xma_pkg::XMA_OP_RL_MEM, xma_pkg::XMA_OP_RL_ACC: r = {m[6:0], m[7]};
			xma_pkg::XMA_OP_RR_MEM, xma_pkg::XMA_OP_RR_ACC: r = {m[0], m[7:1]};
			xma_pkg::XMA_OP_RLC_MEM, xma_pkg::XMA_OP_RLC_ACC: begin
				r = {m[6:0], ef[0]};
				ef[0] = m[7];
			end
			xma_pkg::XMA_OP_RRC_MEM, xma_pkg::XMA_OP_RRC_ACC: begin
				r = {ef[0], m[7:1]};
				ef[0] = m[0];
			end
			xma_pkg::XMA_OP_SBC_ACC, xma_pkg::XMA_OP_SBC_MEM, xma_pkg::XMA_OP_SUB_ACC,
			xma_pkg::XMA_OP_SUB_MEM: begin
				sbc = op inside {xma_pkg::XMA_OP_SBC_ACC, xma_pkg::XMA_OP_SBC_MEM};
				cin = sbc ? ef[0] : 1'b1;
				d = {1'b0, ea} - {1'b0, m} - {8'h00, ~cin};
				lo = {1'b0, ea[3:0]} - {1'b0, m[3:0]} - {4'h0, ~cin};
				r = d[7:0];
				ef[0] = ~d[8];
				ef[1] = ~lo[4];
				ef[2] = (r == 8'h00);
				ef[3] = (ea[7] ^ m[7]) & (ea[7] ^ r[7]);
				ef[4] = r[7] ^ ef[3];
				ef[5] = sbc ? (ef[2] & ef[5]) : ef[2];
			end
			xma_pkg::XMA_OP_DSZ_MEM, xma_pkg::XMA_OP_DSZ_ACC: r = m - 8'h01;
			xma_pkg::XMA_OP_ISZ_MEM, xma_pkg::XMA_OP_ISZ_ACC: r = m + 8'h01;
			xma_pkg::XMA_OP_SET_BYTE: r = 8'hff;
			xma_pkg::XMA_OP_SET_BIT: r = m | (8'h01 << b);
			xma_pkg::XMA_OP_SNZ_BIT: sk = m[b];
			xma_pkg::XMA_OP_SNZ_BYTE: sk = (m != 8'h00);
			xma_pkg::XMA_OP_SWAP_MEM: r = {m[3:0], m[7:4]};
			default: r = ea;
		endcase
		if (op inside {[xma_pkg::XMA_OP_DSZ_MEM : xma_pkg::XMA_OP_ISZ_ACC]}) begin
			sk = (r == 8'h00);
		end
		if (!to_mem) begin
			ea = r;
		end
		@(negedge clock);
		op_valid = 1'b1;
		op_code = op;
		op_addr = a;
		op_bit = b;
		@(negedge clock);
		op_valid = sk;
		op_code = xma_pkg::XMA_OP_SET_BYTE;
		op_addr = 12'h000;
		check("skip", {7'h00, skip_taken}, {7'h00, sk});
		check("dummy", {6'h00, dummy_cycle, busy}, {6'h00, sk, sk});
		check("we", {7'h00, mem_we}, {7'h00, to_mem});
		check("waddr lo", mem_waddr[7:0], a[7:0]);
		check("waddr hi", {4'h0, mem_waddr[11:8]}, {4'h0, a[11:8]});
		check("acc", accumulator_reg, ea);
		check("flags", {2'b00, flags}, {2'b00, ef});
		@(negedge clock);
		op_valid = 1'b0;
		check("we after", {7'h00, mem_we}, 8'h00);
		check("mem", u_mem.mem[a], to_mem ? r : m);
		check("guard", u_mem.mem[12'h000], d0);
	endtask

	// Acc load through a rotate to the accumulator
	task automatic load_acc(input logic [7:0] v);
		u_mem.mem[12'h030] = {v[0], v[7:1]};
		exec(xma_pkg::XMA_OP_RL_ACC, 12'h030, 3'h0);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_or();
		u_mem.mem[12'h011] = 8'ha0;
		u_mem.mem[12'h012] = 8'h00;
		load_acc(8'h1e);
		exec(xma_pkg::XMA_OP_OR_ACC, 12'h011, 3'h0);
		exec(xma_pkg::XMA_OP_OR_MEM, 12'h011, 3'h0);
		load_acc(8'h00);
		exec(xma_pkg::XMA_OP_OR_MEM, 12'h012, 3'h0);
	endtask

	task automatic t_rot();
		for (int i = 3; i <= 10; i++) begin
			u_mem.mem[12'h020] = i[0] ? 8'h81 : 8'h42;
			exec(xma_pkg::xma_op_type'(5'(i)), 12'h020, 3'h0);
		end
	endtask

	task automatic t_sub();
		logic [7:0] av [5] = '{8'h05, 8'h03, 8'h80, 8'h7f, 8'h00};
		logic [7:0] mv [5] = '{8'h03, 8'h05, 8'h01, 8'hff, 8'h00};
		for (int k = 0; k < 5; k++) begin
			for (int i = 11; i <= 14; i++) begin
				load_acc(av[k]);
				u_mem.mem[12'h031] = mv[k];
				exec(xma_pkg::xma_op_type'(5'(i)), 12'h031, 3'h0);
			end
		end
	endtask

	task automatic t_skip();
		logic [7:0] sv [4] = '{8'h01, 8'h00, 8'hff, 8'h02};
		for (int k = 0; k < 4; k++) begin
			for (int i = 15; i <= 18; i++) begin
				u_mem.mem[12'h040] = sv[k];
				exec(xma_pkg::xma_op_type'(5'(i)), 12'h040, 3'h0);
			end
		end
		u_mem.mem[12'h041] = 8'h10;
		exec(xma_pkg::XMA_OP_SNZ_BIT, 12'h041, 3'h4);
		exec(xma_pkg::XMA_OP_SNZ_BIT, 12'h041, 3'h3);
		exec(xma_pkg::XMA_OP_SNZ_BYTE, 12'h041, 3'h0);
		exec(xma_pkg::XMA_OP_SNZ_BYTE, 12'h012, 3'h0);
	endtask

	task automatic t_set_swap();
		u_mem.mem[12'hfff] = 8'h12;
		u_mem.mem[12'h800] = 8'h3c;
		exec(xma_pkg::XMA_OP_SWAP_MEM, 12'hfff, 3'h0);
		exec(xma_pkg::XMA_OP_SET_BIT, 12'h800, 3'h7);
		exec(xma_pkg::XMA_OP_SET_BIT, 12'h800, 3'h0);
		exec(xma_pkg::XMA_OP_SET_BYTE, 12'hfff, 3'h0);
		// Unused code must leave acc, flags and memory alone
		exec(xma_pkg::XMA_OP_NONE, 12'h800, 3'h0);
	endtask

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Bounded run; running out counts as a mismatch
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		op_valid = 1'b0;
		op_code = xma_pkg::XMA_OP_NONE;
		op_addr = 12'h000;
		op_bit = 3'h0;
		u_mem.mem[12'h000] = 8'h5a;
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		t_or();
		t_rot();
		t_sub();
		t_skip();
		t_set_swap();
		summarize();
	end
endmodule
